/* File: core/phy_cable_diag_regs.sv */
// cable reflectometry, symbol tally and crossover management registers
// Operation
// - with extension off, line is held broken 2 ms before a test.
// - with extension on, break grows by counter times 256 ms, capped at 2 s.
// - six-bit high-cycle pattern is sent during test; resets to fixed default.
// - six-bit low-cycle pattern is sent during test; resets to fixed default.
// - management sets enable to start; hardware clears it as completion rises.
// - filter bit on applies spike filtering to reflection samples; off bypasses.
// - cable type reports 00 default, 01 shorted, 10 open, 11 matched.
// - completion flag sets at test end, holds until reset or new start.
// - eight-bit fault distance reported after shorted or open result.
// - tally counts invalid 100BASE-TX code symbols, idle symbols included.
// - tally advances at most once per received packet.
// - tally wraps to zero past maximum, never saturates.
// - crossover-disable clear runs auto crossover; set hands pairs to manual bit.
// - manual bit clear keeps pairs normal; set swaps transmit and receive.
// - heartbeat-disable set suppresses 10BASE-T heartbeat test.
// - read-only bit shows reversed 10BASE-T receive polarity.
// - length register valid only on 100BASE-TX links without open or short.
`timescale 1ns/1ps
module phy_cable_diag_regs #(
  parameter int TICK_CYCLES = phy_diag_pkg::TICK_CYCLES,
  parameter int SAMPLE_W    = 10
) (
  // clock and resets
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire logic                soft_rst_i,
  // management register port
  input  wire logic [4:0]          reg_idx_i,
  input  wire logic                reg_wr_i,
  input  wire logic                reg_rd_i,
  input  wire logic [15:0]         reg_wdata_i,
  output logic      [15:0]         reg_rdata_o,
  output logic                     reg_rvalid_o,
  // reflectometry engine
  output logic                     line_break_o,
  output logic                     tdr_drive_o,
  output logic                     tdr_high_phase_o,
  output logic      [5:0]          tdr_pattern_o,
  input  wire logic                echo_done_i,
  input  wire logic [1:0]          echo_type_i,
  input  wire logic [7:0]          echo_dist_i,
  input  wire logic                adc_valid_i,
  input  wire logic [SAMPLE_W-1:0] adc_sample_i,
  output logic                     adc_filt_valid_o,
  output logic      [SAMPLE_W-1:0] adc_filt_o,
  // 100BASE-TX receiver
  input  wire logic                rx_frame_i,
  input  wire logic                rx_bad_symbol_i,
  input  wire logic                link_100_i,
  output logic                     length_report_on_o,
  // crossover, heartbeat, polarity
  input  wire logic                auto_swap_i,
  input  wire logic                rx_polarity_reversed_i,
  output logic                     auto_xover_on_o,
  output logic                     pair_swap_o,
  output logic                     heartbeat_test_on_o
);
  if (TICK_CYCLES < 1) $error("phy_cable_diag_regs: TICK_CYCLES must be positive");
  if (SAMPLE_W < 2) $error("phy_cable_diag_regs: SAMPLE_W must be at least 2");

  localparam int TW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;

  typedef enum logic [1:0] {ST_IDLE, ST_BREAK, ST_PULSE} diag_state_t;

  // retained fields
  logic        delay_ext_q;
  logic [2:0]  brk_cnt_q;
  logic [5:0]  pat_high_q;
  logic [5:0]  pat_low_q;
  logic        enable_q;
  logic        filter_q;
  logic        xo_dis_q;
  logic        swap_q;
  logic        hb_off_q;
  // fields cleared by either reset, except rdata_q and rvalid_q (hardware reset only)
  logic [1:0]  cable_type_q;
  logic        done_q;
  logic [7:0]  dist_q;
  logic [15:0] tally_q;
  logic        counted_q;
  logic        frame_d_q;
  logic [15:0] rdata_q;
  logic        rvalid_q;
  // sequencer
  diag_state_t state_q;
  diag_state_t state_d;
  logic [TW-1:0] tick_cnt_q;
  logic [11:0] ms_cnt_q;
  logic [11:0] target_q;
  logic        hi_phase_q;

  // register decode
  wire wr_pat  = reg_wr_i && (reg_idx_i == phy_diag_pkg::IDX_PATTERN_DELAY);
  wire wr_ctrl = reg_wr_i && (reg_idx_i == phy_diag_pkg::IDX_CONTROL_STATUS);
  wire wr_xo   = reg_wr_i && (reg_idx_i == phy_diag_pkg::IDX_CROSSOVER);
  wire wen_bit = reg_wdata_i[phy_diag_pkg::ENABLE_BIT];

  // test control
  wire start  = wr_ctrl && wen_bit && !enable_q;
  wire finish = (state_q == ST_PULSE) && echo_done_i;
  wire abort  = wr_ctrl && !wen_bit && enable_q && !finish;

  // line break length in ms, latched at start
  wire [11:0] ext_ms  = 12'(brk_cnt_q) * 12'(phy_diag_pkg::BREAK_STEP_MS);
  wire [11:0] raw_ms  = 12'(phy_diag_pkg::BREAK_BASE_MS) + (delay_ext_q ? ext_ms : 12'h000);
  wire [11:0] brk_ms  = (raw_ms > 12'(phy_diag_pkg::BREAK_CAP_MS)) ?
                        12'(phy_diag_pkg::BREAK_CAP_MS) : raw_ms;
  wire        ms_tick = (state_q == ST_BREAK) && (tick_cnt_q == TW'(TICK_CYCLES - 1));
  wire        brk_end = ms_tick && (ms_cnt_q + 12'h001 == target_q);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d = ST_BREAK;
        end
      end
      ST_BREAK: begin
        if (abort) begin
          state_d = ST_IDLE;
        end else if (brk_end) begin
          state_d = ST_PULSE;
        end
      end
      ST_PULSE: begin
        if (abort || finish) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // sequencer flops; a soft reset leaves a running test alone
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q    <= ST_IDLE;
      tick_cnt_q <= '0;
      ms_cnt_q   <= 12'h000;
      target_q   <= 12'(phy_diag_pkg::BREAK_BASE_MS);
      hi_phase_q <= 1'b1;
    end else begin
      state_q    <= state_d;
      tick_cnt_q <= (state_q != ST_BREAK || ms_tick) ? '0 : tick_cnt_q + TW'(1);
      if (start) begin
        ms_cnt_q <= 12'h000;
        target_q <= brk_ms;
      end else if (ms_tick && !brk_end) begin
        ms_cnt_q <= ms_cnt_q + 12'h001;
      end
      hi_phase_q <= (state_q == ST_PULSE) ? !hi_phase_q : 1'b1;
    end
  end

  // retained fields: hardware reset only
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      delay_ext_q <= 1'b0;
      brk_cnt_q   <= 3'h0;
      pat_high_q  <= phy_diag_pkg::PAT_HIGH_RST;
      pat_low_q   <= phy_diag_pkg::PAT_LOW_RST;
      enable_q    <= 1'b0;
      filter_q    <= 1'b0;
      xo_dis_q    <= 1'b0;
      swap_q      <= 1'b0;
      hb_off_q    <= 1'b0;
    end else begin
      if (wr_pat) begin
        delay_ext_q <= reg_wdata_i[phy_diag_pkg::EXT_BIT];
        brk_cnt_q   <= reg_wdata_i[phy_diag_pkg::BRK_CNT_HI:phy_diag_pkg::BRK_CNT_LO];
        pat_high_q  <= reg_wdata_i[phy_diag_pkg::PAT_HI_HI:phy_diag_pkg::PAT_HI_LO];
        pat_low_q   <= reg_wdata_i[phy_diag_pkg::PAT_LO_HI:phy_diag_pkg::PAT_LO_LO];
      end
      if (finish || abort) begin
        enable_q <= 1'b0;
      end else if (start) begin
        enable_q <= 1'b1;
      end
      if (wr_ctrl) begin
        filter_q <= reg_wdata_i[phy_diag_pkg::FILTER_BIT];
      end
      if (wr_xo) begin
        xo_dis_q <= reg_wdata_i[phy_diag_pkg::XO_DIS_BIT];
        swap_q   <= reg_wdata_i[phy_diag_pkg::SWAP_BIT];
        hb_off_q <= reg_wdata_i[phy_diag_pkg::HB_OFF_BIT];
      end
    end
  end

  // results: cleared by hardware or soft reset
  wire fault_hit = (echo_type_i == phy_diag_pkg::CABLE_SHORTED) ||
                   (echo_type_i == phy_diag_pkg::CABLE_OPEN);

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      cable_type_q <= phy_diag_pkg::CABLE_DEFAULT;
      done_q       <= 1'b0;
      dist_q       <= phy_diag_pkg::DIST_RST;
    end else if (finish) begin
      cable_type_q <= echo_type_i;
      done_q       <= 1'b1;
      // distance has no meaning for a matched cable, so it reads zero
      dist_q       <= fault_hit ? echo_dist_i : phy_diag_pkg::DIST_RST;
    end else if (soft_rst_i) begin
      // a result landing with a soft reset wins; enable and a running test are left alone
      cable_type_q <= phy_diag_pkg::CABLE_DEFAULT;
      done_q       <= 1'b0;
      dist_q       <= phy_diag_pkg::DIST_RST;
    end else if (start) begin
      done_q <= 1'b0;
    end
  end

  // symbol tally: one count per packet, idle errors share the last packet's slot
  wire new_pkt = rx_frame_i && !frame_d_q;
  wire bump    = rx_bad_symbol_i && (!counted_q || new_pkt);

  always_ff @(posedge clock_i) begin
    if (rst_i || soft_rst_i) begin
      tally_q   <= phy_diag_pkg::TALLY_RST;
      counted_q <= 1'b0;
      frame_d_q <= 1'b0;
    end else begin
      frame_d_q <= rx_frame_i;
      if (bump) begin
        tally_q <= tally_q + 16'h0001;
      end
      if (bump) begin
        counted_q <= 1'b1;
      end else if (new_pkt) begin
        counted_q <= 1'b0;
      end
    end
  end

  // read path
  wire [15:0] word_pat = {delay_ext_q, brk_cnt_q, pat_high_q, pat_low_q};
  wire [15:0] word_ctl = {enable_q, filter_q, 3'h0, cable_type_q, done_q, dist_q};
  wire [15:0] word_xo  = {xo_dis_q, 1'b0, swap_q, 1'b0, hb_off_q, 6'h00,
                          rx_polarity_reversed_i, 4'h0};
  wire [15:0] rd_word  = (reg_idx_i == phy_diag_pkg::IDX_PATTERN_DELAY)  ? word_pat :
                         (reg_idx_i == phy_diag_pkg::IDX_CONTROL_STATUS) ? word_ctl :
                         (reg_idx_i == phy_diag_pkg::IDX_BAD_SYMBOL)     ? tally_q  :
                         (reg_idx_i == phy_diag_pkg::IDX_CROSSOVER)      ? word_xo  :
                         16'h0000;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rdata_q  <= 16'h0000;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_i;
      if (reg_rd_i) begin
        rdata_q <= rd_word;
      end
    end
  end

  // sample filter
  sample_if #(.W(SAMPLE_W)) smp ();
  assign smp.valid  = adc_valid_i;
  assign smp.data   = adc_sample_i;
  assign smp.enable = filter_q;

  spike_filter #(.W(SAMPLE_W)) u_filter (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .smp     (smp)
  );

  // outputs
  assign reg_rdata_o         = rdata_q;
  assign reg_rvalid_o        = rvalid_q;
  assign line_break_o        = (state_q == ST_BREAK);
  assign tdr_drive_o         = (state_q == ST_PULSE);
  assign tdr_high_phase_o    = hi_phase_q;
  assign tdr_pattern_o       = hi_phase_q ? pat_high_q : pat_low_q;
  assign adc_filt_valid_o    = smp.filt_valid;
  assign adc_filt_o          = smp.filt_data;
  assign auto_xover_on_o     = !xo_dis_q;
  assign pair_swap_o         = xo_dis_q ? swap_q : auto_swap_i;
  assign heartbeat_test_on_o = !hb_off_q;
  // length is meaningless on 10BASE-T or after a short/open result
  assign length_report_on_o  = link_100_i && !(done_q &&
                               (cable_type_q == phy_diag_pkg::CABLE_SHORTED ||
                                cable_type_q == phy_diag_pkg::CABLE_OPEN));

  // checks
  a_break_base: assert property (@(posedge clock_i) disable iff (rst_i)
    start && !delay_ext_q |=> line_break_o && target_q == 12'h002)
    else $error("base line break not 2 ms");

  a_break_end: assert property (@(posedge clock_i) disable iff (rst_i)
    $fell(line_break_o) && enable_q |-> tdr_drive_o && ms_cnt_q + 12'h001 == target_q)
    else $error("line break ended at wrong ms count");

  a_break_ext: assert property (@(posedge clock_i) disable iff (rst_i)
    start && delay_ext_q |=> target_q == 12'h002 + {1'b0, $past(brk_cnt_q), 8'h00})
    else $error("extended line break wrong");

  a_pattern_sent: assert property (@(posedge clock_i) disable iff (rst_i)
    tdr_drive_o ##1 tdr_drive_o |-> tdr_pattern_o == ($past(hi_phase_q) ? pat_low_q : pat_high_q))
    else $error("pattern halves not alternating");

  a_self_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    tdr_drive_o && echo_done_i && !soft_rst_i |=> !enable_q && done_q && !tdr_drive_o)
    else $error("enable not cleared at completion");

  a_type_report: assert property (@(posedge clock_i) disable iff (rst_i)
    finish && !soft_rst_i |=> cable_type_q == $past(echo_type_i))
    else $error("cable type not captured");

  a_done_hold: assert property (@(posedge clock_i) disable iff (rst_i)
    done_q && !start && !soft_rst_i |=> done_q)
    else $error("completion flag dropped early");

  a_done_set: assert property (@(posedge clock_i) disable iff (rst_i)
    finish |=> done_q)
    else $error("completion flag missed at test end");

  a_fault_dist: assert property (@(posedge clock_i) disable iff (rst_i)
    finish && fault_hit && !soft_rst_i |=> dist_q == $past(echo_dist_i))
    else $error("fault distance not captured");

  a_tally_bump: assert property (@(posedge clock_i) disable iff (rst_i)
    rx_bad_symbol_i && !counted_q && !soft_rst_i |=> tally_q == $past(tally_q) + 16'h0001)
    else $error("bad symbol not counted");

  a_tally_once: assert property (@(posedge clock_i) disable iff (rst_i)
    counted_q && !soft_rst_i && !new_pkt |=> $stable(tally_q))
    else $error("tally advanced twice in a packet");

  a_tally_wrap: assert property (@(posedge clock_i) disable iff (rst_i)
    tally_q == 16'hffff && bump && !soft_rst_i |=> tally_q == 16'h0000)
    else $error("tally did not wrap");

  a_pair_manual: assert property (@(posedge clock_i) disable iff (rst_i)
    wr_xo ##1 xo_dis_q |-> pair_swap_o == $past(reg_wdata_i[phy_diag_pkg::SWAP_BIT]))
    else $error("manual pair select ignored");

  a_polarity_read: assert property (@(posedge clock_i) disable iff (rst_i)
    reg_rd_i && reg_idx_i == phy_diag_pkg::IDX_CROSSOVER |=>
    reg_rdata_o[phy_diag_pkg::POL_BIT] == $past(rx_polarity_reversed_i))
    else $error("polarity bit not reported");
endmodule

/* File: core/phy_diag_pkg.sv */
// constants for the cable-diagnostic and crossover management registers
package phy_diag_pkg;

  // register indices
  localparam logic [4:0] IDX_PATTERN_DELAY  = 5'h18;
  localparam logic [4:0] IDX_CONTROL_STATUS = 5'h19;
  localparam logic [4:0] IDX_BAD_SYMBOL     = 5'h1a;
  localparam logic [4:0] IDX_CROSSOVER      = 5'h1b;

  // reflectometry_pattern_delay fields
  localparam int EXT_BIT    = 15;
  localparam int BRK_CNT_HI = 14;
  localparam int BRK_CNT_LO = 12;
  localparam int PAT_HI_HI  = 11;
  localparam int PAT_HI_LO  = 6;
  localparam int PAT_LO_HI  = 5;
  localparam int PAT_LO_LO  = 0;

  // reflectometry_control_status fields
  localparam int ENABLE_BIT = 15;
  localparam int FILTER_BIT = 14;
  localparam int TYPE_HI    = 10;
  localparam int TYPE_LO    = 9;
  localparam int DONE_BIT   = 8;
  localparam int DIST_HI    = 7;
  localparam int DIST_LO    = 0;

  // crossover_polarity_control fields
  localparam int XO_DIS_BIT = 15;
  localparam int SWAP_BIT   = 13;
  localparam int HB_OFF_BIT = 11;
  localparam int POL_BIT    = 4;

  // values after hardware reset
  localparam logic [5:0]  PAT_HIGH_RST = 6'h2e;
  localparam logic [5:0]  PAT_LOW_RST  = 6'h1d;
  localparam logic [15:0] TALLY_RST    = 16'h0000;
  localparam logic [7:0]  DIST_RST     = 8'h00;

  typedef enum logic [1:0] {
    CABLE_DEFAULT = 2'h0,
    CABLE_SHORTED = 2'h1,
    CABLE_OPEN    = 2'h2,
    CABLE_MATCHED = 2'h3
  } cable_type_t;

  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int TICK_MS       = 1;
  localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
  localparam int BREAK_BASE_MS = 2;
  localparam int BREAK_STEP_MS = 256;
  localparam int BREAK_CAP_S   = 2;
  localparam int BREAK_CAP_MS  = BREAK_CAP_S * 1000;

endpackage

/* File: core/sample_if.sv */
// reflection sample path between the register core and the spike filter
`timescale 1ns/1ps
interface sample_if #(parameter int W = 10);
  logic         valid;
  logic [W-1:0] data;
  logic         enable;
  logic         filt_valid;
  logic [W-1:0] filt_data;

  modport filt (input valid, input data, input enable, output filt_valid, output filt_data);
  modport core (output valid, output data, output enable, input filt_valid, input filt_data);
endinterface

/* File: core/spike_filter.sv */
// three-tap median filter on converted reflection samples, bypassable
`timescale 1ns/1ps
module spike_filter #(
  parameter int W = 10
) (
  input wire logic clock_i,
  input wire logic rst_i,
  sample_if.filt   smp
);
  if (W < 2) $error("spike_filter: W must be at least 2");

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] out_q;
  logic         v_q;

  // median of new sample and the two before it kills single-sample spikes
  wire [W-1:0] lo_ab  = (smp.data < s1_q) ? smp.data : s1_q;
  wire [W-1:0] hi_ab  = (smp.data < s1_q) ? s1_q : smp.data;
  wire [W-1:0] mid_hc = (hi_ab < s2_q) ? hi_ab : s2_q;
  wire [W-1:0] median = (lo_ab < mid_hc) ? mid_hc : lo_ab;

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      s1_q  <= '0;
      s2_q  <= '0;
      out_q <= '0;
      v_q   <= 1'b0;
    end else begin
      v_q <= smp.valid;
      if (smp.valid) begin
        s1_q  <= smp.data;
        s2_q  <= s1_q;
        out_q <= smp.enable ? median : smp.data;
      end
    end
  end

  assign smp.filt_valid = v_q;
  assign smp.filt_data  = out_q;

  a_filter_bypass: assert property (@(posedge clock_i) disable iff (rst_i)
    smp.valid && !smp.enable |=> smp.filt_valid && smp.filt_data == $past(smp.data))
    else $error("unfiltered sample not passed through unchanged");
endmodule

/* File: verif/echo_engine_model.sv */
// behavioural reflectometry engine that answers the register core
`timescale 1ns/1ps
module echo_engine_model (
  // clock and reset
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  // from the register core
  input  wire logic       drive_i,
  input  wire logic       break_i,
  // scenario controls
  input  wire logic       stray_i,
  input  wire logic [7:0] delay_i,
  input  wire logic [1:0] type_i,
  input  wire logic [7:0] dist_i,
  // result towards the core
  output logic            done_o,
  output logic [1:0]      type_o,
  output logic [7:0]      dist_o
);
  logic [7:0] cnt_q;
  logic       done_q;
  wire        answer = drive_i && cnt_q == delay_i;
  // stray pulses during the break must be ignored by the core
  wire        stray = stray_i && break_i;

  always_ff @(posedge clock_i) begin
    cnt_q <= (rst_i || !drive_i) ? 8'h00 : cnt_q + 8'h01;
    done_q <= !rst_i && !done_q && (answer || stray);
  end

  assign done_o = done_q;
  // result lines carry junk when not qualified
  assign type_o = done_q ? type_i : ~type_i;
  assign dist_o = done_q ? dist_i : ~dist_i;
endmodule

/* File: verif/tb_top.sv */
// self-checking bench for the cable diagnostic register block
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {
    logic [4:0]  idx;
    logic [15:0] wd;
    logic [15:0] rx;
    logic [2:0]  o;
  } row_t;

  logic        clock_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        soft_rst_i = 1'b0;
  logic [4:0]  reg_idx_i = 5'h00;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [15:0] reg_rdata_o;
  logic        reg_rvalid_o;
  logic        line_break_o;
  logic        tdr_drive_o;
  logic        tdr_high_phase_o;
  logic [5:0]  tdr_pattern_o;
  logic        echo_done_i;
  logic [1:0]  echo_type_i;
  logic [7:0]  echo_dist_i;
  logic        adc_valid_i = 1'b0;
  logic [9:0]  adc_sample_i = 10'h000;
  logic        adc_filt_valid_o;
  logic [9:0]  adc_filt_o;
  logic        rx_frame_i = 1'b0;
  logic        rx_bad_symbol_i = 1'b0;
  logic        link_100_i = 1'b1;
  logic        length_report_on_o;
  logic        auto_swap_i = 1'b1;
  logic        rx_polarity_reversed_i = 1'b1;
  logic        auto_xover_on_o;
  logic        pair_swap_o;
  logic        heartbeat_test_on_o;
  logic        stray = 1'b0;
  logic [7:0]  e_delay = 8'h00;
  logic [1:0]  e_type = 2'h0;
  logic [7:0]  e_dist = 8'h00;
  logic [15:0] d;
  int          fail_count = 0;
  int          compares = 0;

  // short millisecond keeps the 258 ms break affordable
  localparam int TICK = 4;

  row_t rows [8] = '{
    '{5'h18, 16'hffff, 16'hffff, 3'b111}, '{5'h19, 16'h4000, 16'h4000, 3'b111},
    '{5'h1a, 16'hffff, 16'h0000, 3'b111}, '{5'h05, 16'hffff, 16'h0000, 3'b111},
    '{5'h1b, 16'h8000, 16'h8010, 3'b001}, '{5'h1b, 16'ha000, 16'ha010, 3'b011},
    '{5'h1b, 16'h0800, 16'h0810, 3'b110}, '{5'h1b, 16'hffff, 16'ha810, 3'b010}};

  always #12.5 clock_i = ~clock_i;

  phy_cable_diag_regs #(.TICK_CYCLES(TICK), .SAMPLE_W(10)) dut (
    .clock_i(clock_i), .rst_i(rst_i), .soft_rst_i(soft_rst_i),
    .reg_idx_i(reg_idx_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .line_break_o(line_break_o), .tdr_drive_o(tdr_drive_o),
    .tdr_high_phase_o(tdr_high_phase_o),
    .tdr_pattern_o(tdr_pattern_o), .echo_done_i(echo_done_i), .echo_type_i(echo_type_i),
    .echo_dist_i(echo_dist_i), .adc_valid_i(adc_valid_i), .adc_sample_i(adc_sample_i),
    .adc_filt_valid_o(adc_filt_valid_o), .adc_filt_o(adc_filt_o),
    .rx_frame_i(rx_frame_i), .rx_bad_symbol_i(rx_bad_symbol_i), .link_100_i(link_100_i),
    .length_report_on_o(length_report_on_o), .auto_swap_i(auto_swap_i),
    .rx_polarity_reversed_i(rx_polarity_reversed_i), .auto_xover_on_o(auto_xover_on_o),
    .pair_swap_o(pair_swap_o), .heartbeat_test_on_o(heartbeat_test_on_o));

  echo_engine_model partner (
    .clock_i(clock_i), .rst_i(rst_i), .drive_i(tdr_drive_o), .break_i(line_break_o),
    .stray_i(stray), .delay_i(e_delay), .type_i(e_type), .dist_i(e_dist),
    .done_o(echo_done_i), .type_o(echo_type_i), .dist_o(echo_dist_i));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] i, input logic [15:0] w);
    @(posedge clock_i);
    reg_wr_i <= 1'b1;
    reg_idx_i <= i;
    reg_wdata_i <= w;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
    @(negedge clock_i);
  endtask

  task automatic rd(input logic [4:0] i, output logic [15:0] v);
    @(posedge clock_i);
    reg_rd_i <= 1'b1;
    reg_idx_i <= i;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
    @(negedge clock_i);
    chk({15'h0, reg_rvalid_o}, 16'h0001);
    v = reg_rdata_o;
  endtask

  task automatic rdc(input logic [4:0] i, input logic [15:0] exp);
    logic [15:0] v;
    rd(i, v);
    chk(v, exp);
  endtask

  task automatic hreset();
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
  endtask

  task automatic smp(input logic [9:0] s, output logic [9:0] f);
    @(posedge clock_i);
    adc_valid_i <= 1'b1;
    adc_sample_i <= s;
    @(posedge clock_i);
    adc_valid_i <= 1'b0;
    @(negedge clock_i);
    chk({15'h0, adc_filt_valid_o}, 16'h0001);
    f = adc_filt_o;
  endtask

  task automatic tdr(input int brk, input logic [5:0] ph, input logic [5:0] pl,
                     input logic [1:0] ty, input logic [7:0] di);
    int n;
    logic [15:0] msk;
    logic fault;
    n = 0;
    fault = ty == 2'h1 || ty == 2'h2;
    msk = ty == 2'h3 ? 16'hff00 : 16'hffff;
    e_type <= ty;
    e_dist <= di;
    wr(5'h19, 16'h8000);
    while (line_break_o !== 1'b1 && n < 10) begin
      @(negedge clock_i);
      n++;
    end
    n = 0;
    while (line_break_o === 1'b1 && n < 5000) begin
      n++;
      @(negedge clock_i);
    end
    chk(16'(n), 16'(brk));
    chk({8'h0, tdr_drive_o, tdr_high_phase_o, tdr_pattern_o}, {10'h003, ph});
    @(negedge clock_i);
    chk({9'h0, tdr_high_phase_o, tdr_pattern_o}, {10'h0, pl});
    n = 0;
    while (tdr_drive_o === 1'b1 && n < 100) begin
      @(negedge clock_i);
      n++;
    end
    rd(5'h19, d);
    chk(d & msk, {5'h00, ty, 1'b1, fault ? di : 8'h00} & msk);
    chk({15'h0, length_report_on_o}, {15'h0, !fault});
  endtask

  task automatic pkt(input int nbad);
    @(posedge clock_i);
    rx_frame_i <= 1'b1;
    for (int k = 0; k < nbad; k++) begin
      @(posedge clock_i);
      rx_bad_symbol_i <= 1'b1;
      @(posedge clock_i);
      rx_bad_symbol_i <= 1'b0;
    end
    @(posedge clock_i);
    rx_frame_i <= 1'b0;
    @(posedge clock_i);
  endtask

  task automatic wrap_up();
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    wrap_up();
  end

  initial begin
    logic [9:0] f;
    repeat (6) @(posedge clock_i);
    rst_i <= 1'b0;
    @(negedge clock_i);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].idx, rows[i].wd);
      rdc(rows[i].idx, rows[i].rx);
      chk({13'h0, auto_xover_on_o, pair_swap_o, heartbeat_test_on_o}, {13'h0, rows[i].o});
    end
    // mid-run hardware reset brings every field back
    hreset();
    rdc(5'h18, {4'h0, phy_diag_pkg::PAT_HIGH_RST, phy_diag_pkg::PAT_LOW_RST});
    rdc(5'h19, 16'h0000);
    rdc(5'h1a, phy_diag_pkg::TALLY_RST);
    rdc(5'h1b, 16'h0010);
    chk({9'h0, tdr_high_phase_o, tdr_pattern_o}, {10'h001, phy_diag_pkg::PAT_HIGH_RST});
    @(posedge clock_i);
    rx_polarity_reversed_i <= 1'b0;
    auto_swap_i <= 1'b0;
    rdc(5'h1b, 16'h0000);
    chk({13'h0, auto_xover_on_o, pair_swap_o, heartbeat_test_on_o}, 16'h0005);
    smp(10'h3ff, f);
    chk({6'h0, f}, 16'h03ff);
    for (int t = 0; t < 4; t++) begin
      e_delay <= 8'(t * 3);
      stray <= t == 2;
      tdr(2 * TICK, 6'h2e, 6'h1d, 2'(t), 8'h40 + 8'(t));
    end
    stray <= 1'b0;
    @(posedge clock_i);
    link_100_i <= 1'b0;
    @(negedge clock_i);
    chk({15'h0, length_report_on_o}, 16'h0000);
    @(posedge clock_i);
    link_100_i <= 1'b1;
    wr(5'h18, 16'h954a);
    tdr((2 + 256) * TICK, 6'h15, 6'h0a, 2'h1, 8'h7f);
    // start clears completion; clearing enable mid-break aborts
    wr(5'h19, 16'h8000);
    rd(5'h19, d);
    chk(d & 16'h8100, 16'h8000);
    wr(5'h19, 16'h0000);
    @(negedge clock_i);
    chk({15'h0, line_break_o}, 16'h0000);
    rd(5'h19, d);
    chk(d & 16'h8100, 16'h0000);
    wr(5'h19, 16'h4000);
    for (int k = 0; k < 3; k++)
      smp(10'h014, f);
    smp(10'h3ff, f);
    chk({6'h0, f}, 16'h0014);
    pkt(3);
    rdc(5'h1a, 16'h0001);
    pkt(1);
    rdc(5'h1a, 16'h0002);
    pkt(0);
    rdc(5'h1a, 16'h0002);
    // bad idle symbols outside a frame take one shared slot
    repeat (2) begin
      @(posedge clock_i);
      rx_bad_symbol_i <= 1'b1;
      @(posedge clock_i);
      rx_bad_symbol_i <= 1'b0;
    end
    rdc(5'h1a, 16'h0003);
    wr(5'h1b, 16'h8800);
    @(posedge clock_i);
    soft_rst_i <= 1'b1;
    @(posedge clock_i);
    soft_rst_i <= 1'b0;
    @(negedge clock_i);
    rdc(5'h18, 16'h954a);
    rdc(5'h19, 16'h4000);
    rdc(5'h1a, 16'h0000);
    rdc(5'h1b, 16'h8800);
    wrap_up();
  end
endmodule
